// >>> i2c_master_model.sv
// serial bus master model facing the regulator port
`timescale 1ns/1ps
`include "regport_defines.vh"
module i2c_master_model (
  input wire mclk_in,
  input wire sda_in,
  output reg scl_out,
  output reg sda_low_out
);
  integer qc = 4; // system cycles per quarter bit, raise for a slower bus
  integer nak_cnt = 0; // acknowledges that did not come
  reg [7:0] rd_q [0:15]; // bytes of the last read
  initial begin
    scl_out = 1'b1; // idle bus: both lines high
    sda_low_out = 1'b0;
  end
  task q;
    repeat (qc) @(negedge mclk_in);
  endtask
  // one bit: data moves while clock low, taken in clock high
  task bit_io(input b, output r);
    begin
      sda_low_out = !b;
      q;
      scl_out = 1'b1;
      q;
      r = sda_in;
      q;
      scl_out = 1'b0;
      q;
    end
  endtask
  // start, also used as repeated start
  task start;
    begin
      sda_low_out = 1'b0;
      q;
      scl_out = 1'b1;
      q;
      sda_low_out = 1'b1;
      q;
      scl_out = 1'b0;
      q;
    end
  endtask
  task stop;
    begin
      sda_low_out = 1'b1;
      q;
      scl_out = 1'b1;
      q;
      sda_low_out = 1'b0;
      q;
    end
  endtask
  task wbyte(input [7:0] d, output a);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
      bit_io(1'b1, r);
      a = !r;
      if (!a) nak_cnt = nak_cnt + 1;
    end
  endtask
  task rbyte(input ack, output [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
      bit_io(!ack, r);
    end
  endtask
  task wr(input [3:0] idx, input [7:0] d);
    reg a;
    begin
      start;
      wbyte({`TGT_ADDR, 1'b0}, a);
      wbyte({4'h0, idx}, a);
      wbyte(d, a);
      stop;
    end
  endtask
  task rd(input [3:0] idx, input integer n);
    integer k;
    reg a;
    begin
      start;
      wbyte({`TGT_ADDR, 1'b0}, a);
      wbyte({4'h0, idx}, a);
      start;
      wbyte({`TGT_ADDR, 1'b1}, a);
      for (k = 0; k < n; k = k + 1) rbyte(k < n - 1, rd_q[k]);
      stop;
    end
  endtask
  task hold_low(input integer n);
    begin
      scl_out = 1'b0;
      repeat (n) @(negedge mclk_in);
      scl_out = 1'b1;
      q;
    end
  endtask
endmodule // i2c_master_model

// >>> low_timer.v
// counts how long the clock line stays low and flags a hold-low reset
`timescale 1ns/1ps
`include "regport_defines.vh"
module low_timer #(
  parameter LIMIT = `SCL_LOW_CYCLES
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire scl_in,
  output reg expire_out
);
  reg [24:0] cnt_q; // cycles of continuous low
  // ----------------------------------------
  // count while low, pulse once past limit
  // ----------------------------------------
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 25'h0;
      expire_out <= 1'b0;
    end else if (scl_in) begin
      cnt_q <= 25'h0;
      expire_out <= 1'b0;
    end else begin
      // fire a single pulse when the count passes the limit
      expire_out <= (cnt_q == LIMIT[24:0]);
      if (cnt_q <= LIMIT[24:0]) begin
        cnt_q <= cnt_q + 25'h1;
      end
    end
  end
endmodule // low_timer

// >>> regport_defines.vh
// register map, field positions, reset values and timing counts of the regulator port
`ifndef REGPORT_DEFINES_VH
`define REGPORT_DEFINES_VH
// target address
`define TGT_ADDR 7'h20
// register indexes
`define IDX_ID 4'h0
`define IDX_FAULT 4'h1
`define IDX_STATE 4'h2
`define IDX_MODE 4'h3
`define IDX_VTGT 4'h4
`define IDX_VFLOOR 4'h5
`define IDX_VCEIL 4'h6
`define IDX_SHDN 4'h7
`define IDX_ILIM 4'h8
`define IDX_SRST 4'h9
`define IDX_LAST 4'h9
// identity: part code and revision (arbitrary values)
`define PART_CODE 4'ha
`define SI_REV 4'h3
// reset values
`define RST_MODE 8'h00
`define RST_VTGT 8'h6e
`define RST_VFLOOR 8'h00
`define RST_VCEIL 8'hb4
`define RST_SHDN 8'h08
`define RST_ILIM 8'h00
`define RST_SRST 8'h00
// field positions
`define READY_BIT 6
`define STEP_EN_BIT 3
// clock-low reset time: 100 ms at 4 ns per cycle
`define SCL_LOW_MS 100
`define CLK_PERIOD_NS 4
`define SCL_LOW_CYCLES (`SCL_LOW_MS * 1000000 / `CLK_PERIOD_NS)
`endif

// >>> regport_properties.sv
// assertion checker for the regulator serial port
`timescale 1ns/1ps
`include "regport_defines.vh"
module regport_properties #(
  parameter LOW_LIMIT = 200
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe_out,
  input wire [7:0] operating_control_out,
  input wire [7:0] voltage_target_select_out,
  input wire [7:0] voltage_floor_limit_out,
  input wire [7:0] voltage_ceiling_limit_out,
  input wire [7:0] shutdown_discharge_out,
  input wire [7:0] current_limit_setting_out,
  input wire [7:0] soft_reset_out,
  input wire ramp_start_out
);
  // all writable registers side by side, and their defaults
  wire [55:0] regs_w = {operating_control_out, voltage_target_select_out,
    voltage_floor_limit_out, voltage_ceiling_limit_out, shutdown_discharge_out,
    current_limit_setting_out, soft_reset_out};
  localparam [55:0] DEF = {`RST_MODE, `RST_VTGT, `RST_VFLOOR, `RST_VCEIL,
    `RST_SHDN, `RST_ILIM, `RST_SRST};
  reg [31:0] low_cnt_q; // cycles the clock pin has been low, saturating
  // counts the hold-low time; a clock high restarts it
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) low_cnt_q <= 32'h0;
    else if (scl_in) low_cnt_q <= 32'h0;
    else if (low_cnt_q < LOW_LIMIT + 16) low_cnt_q <= low_cnt_q + 32'h1;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  chk_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin value not low");
  chk_oe_after_fall: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("data drive moved outside clock low");
  chk_oe_hold_high: assert property ($rose(scl_in) |-> $stable(sda_oe_out)[*8])
    else $error("data drive moved during clock high");
  chk_regs_scl_low: assert property ($changed(regs_w) |-> !scl_in)
    else $error("register changed during clock high");
  chk_ramp_one_cycle: assert property (ramp_start_out |=> !ramp_start_out)
    else $error("ramp pulse longer than one cycle");
  chk_ramp_on_change: assert property (ramp_start_out |->
    voltage_target_select_out != $past(voltage_target_select_out, 3))
    else $error("ramp without a new target");
  chk_ramp_scl_low: assert property (ramp_start_out |-> !scl_in)
    else $error("ramp outside a write");
  chk_hold_low_reset: assert property (low_cnt_q == LOW_LIMIT + 16 |-> regs_w == DEF)
    else $error("hold-low did not restore defaults");
endmodule // regport_properties

bind regulator_i2c_register_port regport_properties #(.LOW_LIMIT(LOW_LIMIT)) i_props (
  .mclk_in(mclk_in),
  .nrst_in(nrst_in),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .operating_control_out(operating_control_out),
  .voltage_target_select_out(voltage_target_select_out),
  .voltage_floor_limit_out(voltage_floor_limit_out),
  .voltage_ceiling_limit_out(voltage_ceiling_limit_out),
  .shutdown_discharge_out(shutdown_discharge_out),
  .current_limit_setting_out(current_limit_setting_out),
  .soft_reset_out(soft_reset_out),
  .ramp_start_out(ramp_start_out)
);

// >>> regulator_i2c_register_port.v
// serial target port and register file of the step-down regulator
`timescale 1ns/1ps
`include "regport_defines.vh"
module regulator_i2c_register_port #(
  parameter LOW_LIMIT = `SCL_LOW_CYCLES
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_out,
  input wire [4:0] fault_event_in,
  input wire [5:0] state_in,
  input wire conv_idle_in,
  input wire vin_good_in,
  input wire temp_safe_in,
  output reg [7:0] operating_control_out,
  output reg [7:0] voltage_target_select_out,
  output reg [7:0] voltage_floor_limit_out,
  output reg [7:0] voltage_ceiling_limit_out,
  output reg [7:0] shutdown_discharge_out,
  output reg [7:0] current_limit_setting_out,
  output reg [7:0] soft_reset_out,
  output reg ramp_start_out
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RDAT = 3'd5;
  localparam ST_RACK = 3'd6;

  wire scl_s; // synchronised clock line
  wire sda_s; // synchronised data line
  wire hold_rst; // clock held low too long
  reg scl_d1_q; // previous clock sample
  reg sda_d1_q; // previous data sample
  reg [2:0] st_q; // protocol state
  reg [3:0] bit_q; // bit counter in byte
  reg [7:0] sh_q; // shift register
  reg rw_q; // direction of this transfer
  reg have_idx_q; // register index received
  reg [3:0] idx_q; // register index
  reg [4:0] fault_q; // latched fault flags
  reg drive_low_q; // pull data line low

  // open-drain: output value always low, only the enable moves
  assign sda_out = 1'b0;

  // ----------------------------------------
  // pin synchronisers and hold-low timer
  // ----------------------------------------
  // oversampling at the system clock keeps up with every bus speed grade
  sync2 u_sync_scl (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .d_in(scl_in),
    .q_out(scl_s)
  );
  sync2 u_sync_sda (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .d_in(sda_in),
    .q_out(sda_s)
  );
  low_timer #(
    .LIMIT(LOW_LIMIT)
  ) u_low (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .scl_in(scl_s),
    .expire_out(hold_rst)
  );

  // edge and bus condition decode on oversampled lines
  wire scl_rise = scl_s & ~scl_d1_q;
  wire scl_fall = ~scl_s & scl_d1_q;
  wire start_c = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  wire stop_c = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
  wire addr_hit = (sh_q[7:1] == `TGT_ADDR);

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  function [7:0] rd_mux;
    input [3:0] idx;
    begin
      if (idx == `IDX_ID) begin
        rd_mux = {`PART_CODE, `SI_REV};
      end else if (idx == `IDX_FAULT) begin
        rd_mux = {3'b000, fault_q};
      end else if (idx == `IDX_STATE) begin
        rd_mux = {1'b0, conv_idle_in & vin_good_in & temp_safe_in, state_in};
      end else if (idx == `IDX_MODE) begin
        rd_mux = operating_control_out;
      end else if (idx == `IDX_VTGT) begin
        rd_mux = voltage_target_select_out;
      end else if (idx == `IDX_VFLOOR) begin
        rd_mux = voltage_floor_limit_out;
      end else if (idx == `IDX_VCEIL) begin
        rd_mux = voltage_ceiling_limit_out;
      end else if (idx == `IDX_SHDN) begin
        rd_mux = shutdown_discharge_out;
      end else if (idx == `IDX_ILIM) begin
        rd_mux = current_limit_setting_out;
      end else if (idx == `IDX_SRST) begin
        rd_mux = soft_reset_out;
      end else begin
        rd_mux = 8'h00;
      end
    end
  endfunction

  // ----------------------------------------
  // line history
  // ----------------------------------------
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  // data line enable follows the drive flag
  always @* begin
    sda_oe_out = drive_low_q;
  end

  // write strobe and fault read strobe from the state machine
  reg wr_stb; // data byte received into a register
  reg rd_fault; // fault register byte loaded for sending
  always @* begin
    wr_stb = scl_fall & (st_q == ST_WDAT) & (bit_q == 4'd8) & have_idx_q;
    rd_fault = 1'b0;
    if (scl_fall && st_q == ST_AACK && rw_q && idx_q == `IDX_FAULT) begin
      rd_fault = 1'b1;
    end else if (scl_fall && st_q == ST_RACK && !sda_d1_q &&
                 idx_q + 4'h1 == `IDX_FAULT) begin
      rd_fault = 1'b1;
    end
  end

  // ----------------------------------------
  // protocol state machine
  // ----------------------------------------
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= ST_IDLE;
      bit_q <= 4'd0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      have_idx_q <= 1'b0;
      idx_q <= 4'h0;
      drive_low_q <= 1'b0;
    end else if (hold_rst || stop_c) begin
      // stop or hold-low: release the line and go idle
      st_q <= ST_IDLE;
      drive_low_q <= 1'b0;
      have_idx_q <= 1'b0;
    end else if (start_c) begin
      // start or repeated start restarts address reception
      st_q <= ST_ADDR;
      bit_q <= 4'd0;
      drive_low_q <= 1'b0;
      have_idx_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          drive_low_q <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'd1;
          end else if (scl_fall && bit_q == 4'd8) begin
            if (addr_hit) begin
              rw_q <= sh_q[0];
              drive_low_q <= 1'b1;
              st_q <= ST_AACK;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_q <= 4'd0;
            if (rw_q) begin
              // first read byte comes from the stored index
              sh_q <= rd_mux(idx_q);
              drive_low_q <= ~rd_mux(idx_q) >> 7 == 8'h01;
              st_q <= ST_RDAT;
            end else begin
              drive_low_q <= 1'b0;
              st_q <= ST_WDAT;
            end
          end
        end
        ST_WDAT: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'd1;
          end else if (scl_fall && bit_q == 4'd8) begin
            if (!have_idx_q) begin
              idx_q <= sh_q[3:0];
              have_idx_q <= 1'b1;
            end
            drive_low_q <= 1'b1;
            st_q <= ST_WACK;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            drive_low_q <= 1'b0;
            bit_q <= 4'd0;
            st_q <= ST_WDAT;
          end
        end
        ST_RDAT: begin
          if (scl_fall) begin
            if (bit_q == 4'd7) begin
              drive_low_q <= 1'b0; // release for master ack
              st_q <= ST_RACK;
            end else begin
              drive_low_q <= ~sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'd1;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            if (!sda_d1_q) begin
              // master acked: next register follows
              idx_q <= idx_q + 4'h1;
              sh_q <= rd_mux(idx_q + 4'h1);
              drive_low_q <= ~rd_mux(idx_q + 4'h1) >> 7 == 8'h01;
              bit_q <= 4'd0;
              st_q <= ST_RDAT;
            end else begin
              st_q <= ST_IDLE; // master nack ends the read
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // register file, faults, ramp start
  // ----------------------------------------
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      operating_control_out <= `RST_MODE;
      voltage_target_select_out <= `RST_VTGT;
      voltage_floor_limit_out <= `RST_VFLOOR;
      voltage_ceiling_limit_out <= `RST_VCEIL;
      shutdown_discharge_out <= `RST_SHDN;
      current_limit_setting_out <= `RST_ILIM;
      soft_reset_out <= `RST_SRST;
      fault_q <= 5'h00;
      ramp_start_out <= 1'b0;
    end else if (hold_rst) begin
      // hold-low reset restores every default
      operating_control_out <= `RST_MODE;
      voltage_target_select_out <= `RST_VTGT;
      voltage_floor_limit_out <= `RST_VFLOOR;
      voltage_ceiling_limit_out <= `RST_VCEIL;
      shutdown_discharge_out <= `RST_SHDN;
      current_limit_setting_out <= `RST_ILIM;
      soft_reset_out <= `RST_SRST;
      fault_q <= 5'h00;
      ramp_start_out <= 1'b0;
    end else begin
      // new events win over the read clear
      fault_q <= (rd_fault ? 5'h00 : fault_q) | fault_event_in;
      ramp_start_out <= 1'b0;
      if (wr_stb) begin
        if (idx_q == `IDX_MODE) begin
          operating_control_out <= sh_q;
        end else if (idx_q == `IDX_VTGT) begin
          voltage_target_select_out <= sh_q;
          ramp_start_out <= (sh_q != voltage_target_select_out);
        end else if (idx_q == `IDX_VFLOOR) begin
          voltage_floor_limit_out <= sh_q;
        end else if (idx_q == `IDX_VCEIL) begin
          voltage_ceiling_limit_out <= sh_q;
        end else if (idx_q == `IDX_SHDN) begin
          shutdown_discharge_out <= sh_q;
        end else if (idx_q == `IDX_ILIM) begin
          current_limit_setting_out <= sh_q;
        end else if (idx_q == `IDX_SRST) begin
          soft_reset_out <= sh_q;
        end
      end
    end
  end
endmodule // regulator_i2c_register_port

// >>> sync2.v
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module sync2 (
  input wire mclk_in,
  input wire nrst_in,
  input wire d_in,
  output wire q_out
);
  reg s1_q; // first stage, read only by the second
  reg s2_q; // second stage
  // ----------------------------------------
  // two stage capture, idle-high bus reset
  // ----------------------------------------
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end
  assign q_out = s2_q;
endmodule // sync2

// >>> tb.sv
// testbench of the regulator serial port
`timescale 1ns/1ps
`include "regport_defines.vh"
module tb;
  reg mclk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [4:0] fault_event_in = 5'h00;
  reg [5:0] state_in = 6'h2b;
  reg conv_idle_in = 1'b1;
  reg vin_good_in = 1'b1;
  reg temp_safe_in = 1'b0;
  wire scl_w, low_w, sda_out, sda_oe_out, ramp_start_out;
  wire [7:0] opc_w, vts_w, vfl_w, vce_w, shd_w, cls_w, srs_w;
  wire sda_w = (sda_oe_out ? sda_out : 1'b1) & !low_w; // pulled up when released
  localparam [55:0] DEF = {`RST_MODE, `RST_VTGT, `RST_VFLOOR, `RST_VCEIL,
    `RST_SHDN, `RST_ILIM, `RST_SRST};
  integer n_errors = 0, total_checks = 0, n_ramp = 0, i;
  reg [23:0] rows [0:7]; // index, written byte, byte read back
  reg [7:0] eb [0:8];
  reg a;
  always #2 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (ramp_start_out === 1'b1) n_ramp <= n_ramp + 1;
  regulator_i2c_register_port #(.LOW_LIMIT(200)) i_dut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .fault_event_in(fault_event_in),
    .state_in(state_in), .conv_idle_in(conv_idle_in), .vin_good_in(vin_good_in),
    .temp_safe_in(temp_safe_in), .operating_control_out(opc_w),
    .voltage_target_select_out(vts_w), .voltage_floor_limit_out(vfl_w),
    .voltage_ceiling_limit_out(vce_w), .shutdown_discharge_out(shd_w),
    .current_limit_setting_out(cls_w), .soft_reset_out(srs_w),
    .ramp_start_out(ramp_start_out));
  i2c_master_model i_master (.mclk_in(mclk_in), .sda_in(sda_w), .scl_out(scl_w),
    .sda_low_out(low_w));
  task chk(input [63:0] g, input [63:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // watchdog against a hung bus
  initial begin
    repeat (40000) @(posedge mclk_in);
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    rows = '{24'h035a5a, 24'h051212, 24'h06c3c3, 24'h073c3c, 24'h088181,
      {16'h00ff, `PART_CODE, `SI_REV}, 24'h0a7700, 24'h09a5a5};
    repeat (2) @(negedge mclk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    chk({opc_w, vts_w, vfl_w, vce_w, shd_w, cls_w, srs_w}, DEF);
    for (i = 0; i < 8; i = i + 1) begin
      i_master.wr(rows[i][19:16], rows[i][15:8]);
      i_master.rd(rows[i][19:16], 1);
      chk(i_master.rd_q[0], rows[i][7:0]);
    end
    // ramp only on a changed target
    i = n_ramp;
    i_master.wr(`IDX_MODE, 8'h08);
    i_master.wr(`IDX_VTGT, `RST_VTGT);
    chk(n_ramp - i, 0);
    i_master.wr(`IDX_VTGT, 8'h70);
    chk(n_ramp - i, 1);
    // fault latch, clear on read, ready bit
    @(negedge mclk_in) fault_event_in = 5'h15;
    @(negedge mclk_in) fault_event_in = 5'h00;
    i_master.rd(`IDX_FAULT, 2);
    chk(i_master.rd_q[0], 8'h15);
    chk(i_master.rd_q[1], 8'h2b);
    i_master.rd(`IDX_FAULT, 1);
    chk(i_master.rd_q[0], 8'h00);
    // slow burst read of the map from the identity register up to the current limit register
    temp_safe_in = 1'b1;
    i_master.qc = 8;
    i_master.rd(`IDX_ID, 9);
    i_master.qc = 4;
    eb = '{{`PART_CODE, `SI_REV}, 8'h00, 8'h6b, 8'h08, 8'h70, 8'h12, 8'hc3, 8'h3c, 8'h81};
    for (i = 0; i < 9; i = i + 1) chk(i_master.rd_q[i], eb[i]);
    // foreign address gets no acknowledge
    i_master.start;
    i_master.wbyte({7'h21, 1'b0}, a);
    i_master.stop;
    chk(a, 0);
    i_master.hold_low(150);
    chk(vfl_w, 8'h12);
    i_master.hold_low(260);
    chk({opc_w, vts_w, vfl_w, vce_w, shd_w, cls_w, srs_w}, DEF);
    chk(i_master.nak_cnt, 1);
    // mid-run reset restores defaults and the port still answers after it
    i_master.wr(`IDX_VFLOOR, 8'h33);
    chk(vfl_w, 8'h33);
    @(negedge mclk_in) nrst_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    chk({opc_w, vts_w, vfl_w, vce_w, shd_w, cls_w, srs_w}, DEF);
    i_master.rd(`IDX_VFLOOR, 1);
    chk(i_master.rd_q[0], `RST_VFLOOR);
    close_out;
  end
endmodule // tb
